/* hdl/prc_top.sv */
// Pin reset and power control: register file, pin reset timer,
// sleep refresh pacing and decoded power control outputs.
// Assumes a 10 MHz clk_sys, a free running slow RC clock arriving as
// a plain pin, and a simple strobe register port.
`timescale 1ns/100ps
module prc_top #(
   parameter int NUM_PINS     = prc_pkg::NUM_PINS,
   parameter int TICKS_UNIT   = prc_pkg::TICKS_PER_UNIT,
   parameter int REFRESH_TICK = prc_pkg::REFRESH_UNIT_TICKS
) (
   input  wire logic                clk_sys,
   input  wire logic                rst_n,
   // Register port
   input  wire logic [31:0]         reg_addr,
   input  wire logic [15:0]         reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic      [15:0]         reg_rdata,
   // Pins
   input  wire logic [NUM_PINS-1:0] port0_pin,
   input  wire logic                reset_pad_n,
   input  wire logic                slow_rc_clock,
   // Reset outputs
   output logic                     power_on_reset_event,
   output logic                     pad_reset,
   // Periodic bandgap refresh
   output logic                     reference_refresh,
   // Power controls
   output logic                     rail_switch_auto,
   output logic                     rail_switch_closed,
   output logic                     high_rail_monitor_nohyst,
   output logic                     high_rail_monitor_level,
   output logic                     high_rail_monitor_off,
   output logic                     low_rail_monitor_nohyst,
   output logic                     low_rail_monitor_level,
   output logic                     low_rail_monitor_off,
   output logic                     charge_pump_off,
   output logic                     core_regulator_off,
   output logic                     core_regulator_retain,
   output logic                     reference_hold_force,
   output logic                     high_ok_cmp_enable,
   output logic                     high_nok_cmp_enable,
   input  wire logic                sleep_mode,
   output logic                     low_regulator_on,
   output logic                     low_regulator_high_current,
   // Crystal controls
   output logic                     crystal_dcblock_enable,
   output logic                     amplitude_bias_keep,
   output logic      [2:0]          crystal_current_trim,
   output logic      [2:0]          crystal_amplitude_trim
);

   // ----------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------
   localparam int UNIT_W = $clog2(TICKS_UNIT + 1);
   localparam int REF_W  = $clog2(REFRESH_TICK + 1);

   logic [9:0]  crystal_core_control;
   logic [7:0]  reset_pin_config;
   logic [6:0]  reset_hold_timer;
   logic [11:0] sleep_refresh_config;
   logic [15:0] power_supply_control;
   logic [9:0]  next_crystal;
   logic [7:0]  next_pin_cfg;
   logic [6:0]  next_timer;
   logic [11:0] next_sleep;
   logic [15:0] next_power;
   logic [15:0] next_rdata;

   logic [NUM_PINS-1:0] pins_s;
   logic                pad_n_s;
   logic                slow_s;
   logic                slow_q;
   logic                next_slow_q;
   logic                slow_tick;

   logic              pin_active;
   logic [UNIT_W-1:0] unit_cnt;
   logic [UNIT_W-1:0] next_unit_cnt;
   logic [6:0]        unit_done;
   logic [6:0]        next_unit_done;
   logic              next_por;

   logic [REF_W-1:0] ref_tick_cnt;
   logic [REF_W-1:0] next_ref_tick_cnt;
   logic [11:0]      ref_units;
   logic [11:0]      next_ref_units;
   logic             next_refresh;

   // Select field maps to one pin, or none for off and reserved codes
   function automatic logic pick_pin(input logic [3:0] sel,
                                     input logic [NUM_PINS-1:0] pins);
      logic hit;
      hit = 1'b0;
      if (sel >= prc_pkg::SEL_FIRST && sel <= prc_pkg::SEL_LAST) begin
         hit = pins[sel - prc_pkg::SEL_FIRST]; // R3
      end
      return hit;
   endfunction

   // ----------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------
   prc_sync #(
      .WIDTH (NUM_PINS + 2)
   ) u_sync (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .async_in ({port0_pin, reset_pad_n, slow_rc_clock}),
      .sync_out ({pins_s, pad_n_s, slow_s})
   );

   // ----------------------------------------------------------
   // Register file
   // ----------------------------------------------------------
   // Writes land on the next edge and steer outputs at once
   always_comb begin
      next_crystal = crystal_core_control;
      next_pin_cfg = reset_pin_config;
      next_timer   = reset_hold_timer;
      next_sleep   = sleep_refresh_config;
      next_power   = power_supply_control;
      next_rdata   = 16'h0000;
      if (reg_wr) begin
         if (reg_addr == prc_pkg::ADDR_CRYSTAL) begin
            next_crystal = reg_wdata[9:0]; // R19
         end else if (reg_addr == prc_pkg::ADDR_PIN_CFG) begin
            next_pin_cfg = reg_wdata[7:0];
         end else if (reg_addr == prc_pkg::ADDR_TIMER) begin
            next_timer = reg_wdata[6:0];
         end else if (reg_addr == prc_pkg::ADDR_SLEEP) begin
            next_sleep = reg_wdata[11:0];
         end else if (reg_addr == prc_pkg::ADDR_POWER) begin
            next_power = reg_wdata;
         end
      end
      // Unmapped addresses read as zero
      if (reg_rd) begin
         if (reg_addr == prc_pkg::ADDR_CRYSTAL) begin
            next_rdata = {6'h00, crystal_core_control};
         end else if (reg_addr == prc_pkg::ADDR_PIN_CFG) begin
            next_rdata = {8'h00, reset_pin_config};
         end else if (reg_addr == prc_pkg::ADDR_TIMER) begin
            next_rdata = {9'h000, reset_hold_timer};
         end else if (reg_addr == prc_pkg::ADDR_SLEEP) begin
            next_rdata = {4'h0, sleep_refresh_config};
         end else if (reg_addr == prc_pkg::ADDR_POWER) begin
            next_rdata = power_supply_control;
         end
      end
      if (!rst_n) begin
         next_crystal = prc_pkg::RST_CRYSTAL; // R16 R17
         next_pin_cfg = prc_pkg::RST_PIN_CFG;
         next_timer   = prc_pkg::RST_TIMER;   // R6
         next_sleep   = prc_pkg::RST_SLEEP;   // R8
         next_power   = prc_pkg::RST_POWER;   // R12 R13
         next_rdata   = 16'h0000;
      end
   end

   // Register file storage
   always_ff @(posedge clk_sys) begin
      crystal_core_control <= next_crystal;
      reset_pin_config     <= next_pin_cfg;
      reset_hold_timer     <= next_timer;
      sleep_refresh_config <= next_sleep;
      power_supply_control <= next_power;
      reg_rdata            <= next_rdata;
   end

   // ----------------------------------------------------------
   // Slow clock edge detect
   // ----------------------------------------------------------
   // Sampled as a level; 10 MHz is far above 32 kHz so no tick is lost
   assign slow_tick = slow_s & ~slow_q;

   always_comb begin
      next_slow_q = slow_s;
      if (!rst_n) begin
         next_slow_q = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      slow_q <= next_slow_q;
   end

   // ----------------------------------------------------------
   // Pin reset timer
   // ----------------------------------------------------------
   // Polarity bit flips the selected pin only; the pad never sees it
   assign pin_active = pick_pin(reset_pin_config[3:0], pins_s)
                       ^ ~reset_pin_config[prc_pkg::PIN_POL]; // R1 R2

   // Counts whole units of 4096 slow ticks while the pin stays active.
   // The reset fires once per hold and stays until the pin is released, the time field is zeroed or the select goes off.
   always_comb begin
      next_unit_cnt  = unit_cnt;
      next_unit_done = unit_done;
      next_por       = power_on_reset_event;
      if (!pin_active || reset_hold_timer == 7'h00 ||
          reset_pin_config[3:0] == prc_pkg::SEL_OFF) begin
         next_unit_cnt  = '0; // R5 R7
         next_unit_done = 7'h00;
         next_por       = 1'b0;
      end else if (unit_done >= reset_hold_timer) begin
         next_por = 1'b1; // R7
      end else if (slow_tick) begin
         if (unit_cnt == UNIT_W'(TICKS_UNIT - 1)) begin
            next_unit_cnt  = '0; // R4
            next_unit_done = unit_done + 7'h01;
         end else begin
            next_unit_cnt = unit_cnt + UNIT_W'(1);
         end
      end
      if (!rst_n) begin
         next_unit_cnt  = '0;
         next_unit_done = 7'h00;
         next_por       = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      unit_cnt             <= next_unit_cnt;
      unit_done            <= next_unit_done;
      power_on_reset_event <= next_por;
   end

   // ----------------------------------------------------------
   // Bandgap refresh pacing
   // ----------------------------------------------------------
   // One pulse every field x 2 ms; a zero field stops the pulses
   always_comb begin
      next_ref_tick_cnt = ref_tick_cnt;
      next_ref_units    = ref_units;
      next_refresh      = 1'b0;
      if (slow_tick) begin
         if (ref_tick_cnt == REF_W'(REFRESH_TICK - 1)) begin
            next_ref_tick_cnt = '0;
            if (ref_units + 12'h001 >= sleep_refresh_config) begin
               next_ref_units = 12'h000; // R8
               next_refresh   = (sleep_refresh_config != 12'h000);
            end else begin
               next_ref_units = ref_units + 12'h001;
            end
         end else begin
            next_ref_tick_cnt = ref_tick_cnt + REF_W'(1);
         end
      end
      if (!rst_n) begin
         next_ref_tick_cnt = '0;
         next_ref_units    = 12'h000;
         next_refresh      = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      ref_tick_cnt      <= next_ref_tick_cnt;
      ref_units         <= next_ref_units;
      reference_refresh <= next_refresh;
   end

   // ----------------------------------------------------------
   // Decoded control outputs
   // ----------------------------------------------------------
   // Dedicated pad keeps its fixed active low sense
   assign pad_reset = ~pad_n_s; // R2

   // Manual switch follows bit 2; auto hands it to the boost logic
   assign rail_switch_auto   = power_supply_control[prc_pkg::PW_AUTO]; // R9
   assign rail_switch_closed = ~power_supply_control[prc_pkg::PW_AUTO]
                               & power_supply_control[prc_pkg::PW_SWITCH]; // R10
   assign high_rail_monitor_nohyst =
      power_supply_control[prc_pkg::PW_HI_NOHYST]; // R12
   assign high_rail_monitor_level  =
      power_supply_control[prc_pkg::PW_HI_LEVEL];  // R12
   assign high_rail_monitor_off    =
      power_supply_control[prc_pkg::PW_HI_OFF];    // R12
   assign low_rail_monitor_nohyst  =
      power_supply_control[prc_pkg::PW_LO_NOHYST]; // R13
   assign low_rail_monitor_level   =
      power_supply_control[prc_pkg::PW_LO_LEVEL];  // R13
   assign low_rail_monitor_off     =
      power_supply_control[prc_pkg::PW_LO_OFF];    // R13
   assign charge_pump_off       =
      power_supply_control[prc_pkg::PW_CP_OFF];    // R14
   assign core_regulator_off    =
      power_supply_control[prc_pkg::PW_CORE_OFF];  // R14
   assign core_regulator_retain =
      power_supply_control[prc_pkg::PW_RETAIN];    // R14
   assign reference_hold_force  =
      power_supply_control[prc_pkg::PW_VREF_HOLD]; // R15
   assign high_ok_cmp_enable    = power_supply_control[prc_pkg::PW_HI_OK_EN];
   assign high_nok_cmp_enable   =
      power_supply_control[prc_pkg::PW_HI_NOK_EN];

   // Low regulator mode against the present sleep state
   always_comb begin
      low_regulator_on           = 1'b0;
      low_regulator_high_current = 1'b0;
      case (prc_pkg::prc_ldo_mode_t'(
            power_supply_control[prc_pkg::PW_LDO_LO +: 2]))
         prc_pkg::PRC_LDO_HI_OFF: begin
            low_regulator_on           = ~sleep_mode; // R11
            low_regulator_high_current = ~sleep_mode;
         end
         prc_pkg::PRC_LDO_OFF: begin
            low_regulator_on = 1'b0;
         end
         prc_pkg::PRC_LDO_LO_LO: begin
            low_regulator_on = 1'b1;
         end
         default: begin
            low_regulator_on           = 1'b1;
            low_regulator_high_current = ~sleep_mode;
         end
      endcase
   end

   // Crystal core fields
   assign crystal_dcblock_enable =
      crystal_core_control[prc_pkg::XT_DCBLOCK];      // R16
   assign amplitude_bias_keep    =
      crystal_core_control[prc_pkg::XT_BIAS_KEEP];    // R18
   assign crystal_current_trim   =
      crystal_core_control[prc_pkg::XT_CUR_LO +: 3];  // R17
   assign crystal_amplitude_trim =
      crystal_core_control[prc_pkg::XT_AMP_LO +: 3];  // R17

endmodule

/* shared/prc_pkg.sv */
// Package for the pin reset and power control block: register offsets,
// field positions, reset values and timing counts.
// Assumes a 10 MHz system clock and a slow RC clock on a separate pin.
//
// Summary of operation
// (R1) Pin polarity bit 7: 0 low, 1 high
// (R2) Polarity affects pin source only, not pad
// (R3) Select 0 off, 1..C pick pins 0..11
// (R4) Delay equals time field times 4096 ticks
// (R5) Time field zero disables pin reset timer
// (R6) Time field resets to 0x18
// (R7) Pin held active full delay; restart otherwise
// (R8) Refresh interval field times 2 ms, reset 0x80
// (R9) Bit 15 selects manual or automatic switch
// (R10) Manual: bit 2 opens or closes switch
// (R11) Low regulator mode field decodes four modes
// (R12) High rail monitor: nohyst, level, disable bits
// (R13) Low rail monitor: nohyst, level, disable bits
// (R14) Charge pump off, core off, core retain
// (R15) Bit 7 forces regulator references to hold
// (R16) Bit 0 enables crystal dc block, reset 1
// (R17) Current trim 4:2 reset 5; amplitude 7:5
// (R18) Bit 1 keeps amplitude detector bias alive
// (R19) Fields are read/write and act immediately
package prc_pkg;

   // -------------------------------------------------------------
   // Register offsets
   // -------------------------------------------------------------
   localparam logic [31:0] ADDR_CRYSTAL = 32'h5000_0038;
   localparam logic [31:0] ADDR_PIN_CFG = 32'h5000_0040;
   localparam logic [31:0] ADDR_TIMER   = 32'h5000_0042;
   localparam logic [31:0] ADDR_SLEEP   = 32'h5000_0050;
   localparam logic [31:0] ADDR_POWER   = 32'h5000_0052;

   // -------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------
   localparam logic [9:0]  RST_CRYSTAL = 10'h015;
   localparam logic [7:0]  RST_PIN_CFG = 8'h00;
   localparam logic [6:0]  RST_TIMER   = 7'h18;
   localparam logic [11:0] RST_SLEEP   = 12'h080;
   localparam logic [15:0] RST_POWER   = 16'h4000;

   // -------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------
   localparam int XT_DCBLOCK   = 0;
   localparam int XT_BIAS_KEEP = 1;
   localparam int XT_CUR_LO    = 2;
   localparam int XT_AMP_LO    = 5;
   localparam int PIN_POL      = 7;
   localparam int PW_AUTO      = 15;
   localparam int PW_HI_NOHYST = 14;
   localparam int PW_HI_LEVEL  = 13;
   localparam int PW_HI_OFF    = 12;
   localparam int PW_LO_NOHYST = 11;
   localparam int PW_LO_LEVEL  = 10;
   localparam int PW_LO_OFF    = 9;
   localparam int PW_CP_OFF    = 8;
   localparam int PW_VREF_HOLD = 7;
   localparam int PW_LDO_LO    = 5;
   localparam int PW_CORE_OFF  = 4;
   localparam int PW_RETAIN    = 3;
   localparam int PW_SWITCH    = 2;
   localparam int PW_HI_OK_EN  = 1;
   localparam int PW_HI_NOK_EN = 0;

   // -------------------------------------------------------------
   // Pin selection codes and low regulator modes
   // -------------------------------------------------------------
   localparam logic [3:0] SEL_OFF   = 4'h0;
   localparam logic [3:0] SEL_FIRST = 4'h1;
   localparam logic [3:0] SEL_LAST  = 4'hC;
   localparam int         NUM_PINS  = 12;

   typedef enum logic [1:0] {
      PRC_LDO_HI_OFF = 2'b00,
      PRC_LDO_OFF    = 2'b01,
      PRC_LDO_LO_LO  = 2'b10,
      PRC_LDO_HI_LO  = 2'b11
   } prc_ldo_mode_t;

   // -------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------
   localparam int TICKS_PER_UNIT  = 4096;  // Slow clock periods per unit
   localparam int REFRESH_UNIT_MS = 2;
   localparam int SYS_CLK_HZ      = 10_000_000;
   localparam int SLOW_CLK_HZ     = 32_000;
   // Slow clock periods in one refresh unit, rounded down
   localparam int REFRESH_UNIT_TICKS =
      (SLOW_CLK_HZ * REFRESH_UNIT_MS) / 1000;

endpackage

/* hdl/prc_sync.sv */
// Two-flop synchroniser for a bus of asynchronous levels.
// Assumes inputs are quasi-static levels from pins or another clock.
`timescale 1ns/100ps
module prc_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] next_stage1;
   logic [WIDTH-1:0] next_sync_out;

   // ----------------------------------------------------------
   // Next values
   // ----------------------------------------------------------
   // First stage is read only by the second stage
   always_comb begin
      next_stage1   = async_in;
      next_sync_out = stage1;
      if (!rst_n) begin
         next_stage1   = '0;
         next_sync_out = '0;
      end
   end

   // Registers
   always_ff @(posedge clk_sys) begin
      stage1   <= next_stage1;
      sync_out <= next_sync_out;
   end

endmodule

/* bench/prc_top_asserts.sv */
// Checker for the pin reset and power control block.
// Assumes it is bound into prc_top and sees only that module's ports.
`timescale 1ns/100ps
module prc_top_asserts (
   input wire logic        clk_sys,
   input wire logic        rst_n,
   input wire logic [31:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic        reset_pad_n,
   input wire logic        power_on_reset_event,
   input wire logic        pad_reset,
   input wire logic        reference_refresh,
   input wire logic        rail_switch_auto,
   input wire logic        rail_switch_closed,
   input wire logic        low_regulator_on,
   input wire logic        crystal_dcblock_enable,
   input wire logic        amplitude_bias_keep,
   input wire logic [2:0]  crystal_current_trim,
   input wire logic [2:0]  crystal_amplitude_trim
);
   // -------------------------------------------------------------
   // Register write events
   // -------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence s_pw_wr;
      reg_wr && reg_addr == prc_pkg::ADDR_POWER;
   endsequence
   sequence s_xt_wr;
      reg_wr && reg_addr == prc_pkg::ADDR_CRYSTAL;
   endsequence
   sequence s_pin_wr;
      reg_wr && reg_addr == prc_pkg::ADDR_PIN_CFG;
   endsequence

   // -------------------------------------------------------------
   // Properties
   // -------------------------------------------------------------
   a_rdata_idle_zero: assert property (
      !reg_rd |=> reg_rdata == 16'h0000) else $error("stray read data");
   a_auto_opens_switch: assert property (
      rail_switch_auto |-> !rail_switch_closed) else $error("switch closed");
   a_switch_write: assert property (
      s_pw_wr |=> rail_switch_auto == $past(reg_wdata[15]) &&
      rail_switch_closed == ($past(reg_wdata[2]) && !$past(reg_wdata[15])))
      else $error("switch write lost");
   a_ldo_off_mode: assert property (
      s_pw_wr ##0 reg_wdata[6:5] == 2'h1 |=> !low_regulator_on)
      else $error("regulator on in off mode");
   a_xtal_trim_write: assert property (
      s_xt_wr |=> crystal_current_trim == $past(reg_wdata[4:2]) &&
      crystal_amplitude_trim == $past(reg_wdata[7:5]))
      else $error("trim write lost");
   a_xtal_flag_write: assert property (
      s_xt_wr |=> crystal_dcblock_enable == $past(reg_wdata[0]) &&
      amplitude_bias_keep == $past(reg_wdata[1]))
      else $error("flag write lost");
   a_refresh_single: assert property (
      reference_refresh |=> !reference_refresh) else $error("long pulse");
   a_pad_low_reset: assert property (
      !reset_pad_n [*4] |-> pad_reset) else $error("pad reset missing");
   a_pad_high_idle: assert property (
      reset_pad_n [*4] |-> !pad_reset) else $error("pad reset stuck");
   a_sel_off_drops: assert property (
      s_pin_wr ##0 reg_wdata[3:0] == 4'h0 |-> ##[1:4] !power_on_reset_event)
      else $error("pin reset with select off");
endmodule

bind prc_top prc_top_asserts i_chk (.*);

/* bench/tb.sv */
// Self-checking bench for the pin reset and power control block.
// Assumes short slow counts and an 8-cycle slow clock.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
   fail_count++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb;
   localparam int TU = 4;  // Delay unit in slow ticks, kept short
   localparam int RT = 2;  // Refresh unit in slow ticks, kept short
   localparam int SP = 8;  // System cycles per slow clock period
   logic        clk_sys = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
   logic [31:0] reg_addr = 32'h0;
   logic [15:0] reg_wdata = 16'h0, reg_rdata, pw_out;
   logic [11:0] port0_pin = 12'h0, idle;
   logic        reset_pad_n = 1'h1, slow_rc_clock = 1'h0, sleep_mode = 1'h0;
   logic        power_on_reset_event, pad_reset, reference_refresh;
   logic        rail_switch_auto, rail_switch_closed, charge_pump_off;
   logic        high_rail_monitor_nohyst, high_rail_monitor_level;
   logic        high_rail_monitor_off, low_rail_monitor_nohyst;
   logic        low_rail_monitor_level, low_rail_monitor_off;
   logic        core_regulator_off, core_regulator_retain;
   logic        reference_hold_force, high_ok_cmp_enable;
   logic        high_nok_cmp_enable, low_regulator_on;
   logic        low_regulator_high_current, crystal_dcblock_enable;
   logic        amplitude_bias_keep, pol;
   logic [2:0]  crystal_current_trim, crystal_amplitude_trim;
   logic [3:0]  sels [3] = '{4'h1, 4'h7, 4'hC};
   logic [15:0] ncfg [3] = '{16'h0082, 16'h008D, 16'h0081};
   logic [15:0] ntim [3] = '{16'h0001, 16'h0001, 16'h0000};
   int          fail_count = 0, check_count = 0, div = 0, c, i, m;

   // -------------------------------------------------------------
   // Clocks and design
   // -------------------------------------------------------------
   always #50 clk_sys = ~clk_sys;
   // Slow clock made on the system edge: fixed phase
   always @(posedge clk_sys) begin
      div <= (div == SP / 2 - 1) ? 0 : div + 1;
      if (div == SP / 2 - 1) slow_rc_clock <= ~slow_rc_clock;
   end
   assign pw_out = {rail_switch_auto, high_rail_monitor_nohyst,
      high_rail_monitor_level, high_rail_monitor_off, low_rail_monitor_nohyst,
      low_rail_monitor_level, low_rail_monitor_off, charge_pump_off,
      reference_hold_force, 2'h0, core_regulator_off, core_regulator_retain,
      rail_switch_closed, high_ok_cmp_enable, high_nok_cmp_enable};
   prc_top #(.TICKS_UNIT(TU), .REFRESH_TICK(RT)) i_dut (.*);

   // -------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------
   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wr(input logic [31:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge clk_sys);
      reg_wr <= 1'h0;
      #1;
   endtask
   task automatic rd(input logic [31:0] a, input logic [15:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clk_sys);
      reg_rd <= 1'h0;
      #1;
      `CHK("read data", e, reg_rdata)
   endtask
   // Bounded wait; running out ends the run
   task automatic wait_por(input logic lvl, input int lim);
      c = 0;
      while (power_on_reset_event !== lvl && c < lim) begin
         @(posedge clk_sys);
         #1;
         c++;
      end
      if (c >= lim) begin
         `CHK("pin reset wait", lvl, power_on_reset_event)
         complete_run();
      end
   endtask
   task automatic set_pins(input logic [11:0] v, input int n);
      @(posedge clk_sys);
      port0_pin <= v;
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge clk_sys);
      fail_count++;
      complete_run();
   end
   initial begin
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'h1;
      rd(prc_pkg::ADDR_CRYSTAL, 16'h0015);
      rd(prc_pkg::ADDR_PIN_CFG, 16'h0000);
      rd(prc_pkg::ADDR_TIMER, 16'h0018);
      rd(prc_pkg::ADDR_SLEEP, 16'h0080);
      rd(prc_pkg::ADDR_POWER, 16'h4000);
      rd(32'h5000_0044, 16'h0000);
      wr(prc_pkg::ADDR_TIMER, 16'hFFFF);
      rd(prc_pkg::ADDR_TIMER, 16'h007F);
      wr(prc_pkg::ADDR_CRYSTAL, 16'h036A);
      rd(prc_pkg::ADDR_CRYSTAL, 16'h036A);
      `CHK("crystal", 8'h6A, {crystal_amplitude_trim, crystal_current_trim,
         amplitude_bias_keep, crystal_dcblock_enable})
      $display("test registers done");
      for (i = 0; i < 16; i++) begin
         if (i == 5 || i == 6) continue;
         wr(prc_pkg::ADDR_POWER, 16'h0001 << i);
         rd(prc_pkg::ADDR_POWER, 16'h0001 << i);
         `CHK("power outputs", 16'h0001 << i, pw_out)
      end
      wr(prc_pkg::ADDR_POWER, 16'h8004);
      `CHK("auto switch", 16'h8000, pw_out)
      for (i = 0; i < 8; i++) begin
         m = i / 2;
         wr(prc_pkg::ADDR_POWER, 16'(m << 5));
         @(posedge clk_sys);
         sleep_mode <= i[0];
         #1;
         `CHK("low regulator", {m != 1 && !(m == 0 && i[0]),
            (m == 0 || m == 3) && !i[0]},
            {low_regulator_on, low_regulator_high_current})
      end
      $display("test power control done");
      wr(prc_pkg::ADDR_TIMER, 16'h0001);
      for (i = 0; i < 3; i++) begin
         pol = ~i[0];
         idle = pol ? 12'h000 : 12'hFFF;
         set_pins(idle, 4);
         wr(prc_pkg::ADDR_PIN_CFG, {8'h00, pol, 3'h0, sels[i]});
         set_pins(idle ^ (12'h001 << (sels[i] - 1)), 0);
         wait_por(1'h1, 80);
         `CHK("delay low", 1'h1, c >= (TU - 1) * SP)
         `CHK("delay high", 1'h1, c <= TU * SP + 8)
         set_pins(idle, 0);
         wait_por(1'h0, 8);
      end
      // Short pulse then release: the count must start over
      set_pins(12'h800, 2 * SP);
      set_pins(12'h000, 2);
      set_pins(12'hFFF, 0);
      wait_por(1'h1, 80);
      `CHK("restart", 1'h1, c >= (TU - 1) * SP)
      wr(prc_pkg::ADDR_PIN_CFG, 16'h0080);
      wait_por(1'h0, 8);
      for (i = 0; i < 3; i++) begin
         wr(prc_pkg::ADDR_TIMER, ntim[i]);
         wr(prc_pkg::ADDR_PIN_CFG, ncfg[i]);
         set_pins(i == 1 ? 12'hFFF : 12'h001, 10 * SP);
         `CHK("no pin reset", 1'h0, power_on_reset_event)
         set_pins(12'h000, 2);
      end
      set_pins(12'h000, 0);
      @(posedge clk_sys);
      reset_pad_n <= 1'h0;
      repeat (4) @(posedge clk_sys);
      #1;
      `CHK("pad reset", 1'h1, pad_reset)
      `CHK("pad not pin", 1'h0, power_on_reset_event)
      @(posedge clk_sys);
      reset_pad_n <= 1'h1;
      repeat (4) @(posedge clk_sys);
      #1;
      `CHK("pad release", 1'h0, pad_reset)
      $display("test pin reset done");
      wr(prc_pkg::ADDR_SLEEP, 16'h0002);
      for (m = 0; m < 2; m++) begin
         c = 0;
         do begin
            @(posedge clk_sys);
            #1;
            c++;
         end while (reference_refresh !== 1'h1 && c < 100);
      end
      `CHK("refresh period", 2 * RT * SP, c)
      wr(prc_pkg::ADDR_SLEEP, 16'h0000);
      c = 0;
      repeat (100) begin
         @(posedge clk_sys);
         #1;
         if (reference_refresh !== 1'h0) c++;
      end
      `CHK("refresh off", 0, c)
      $display("test refresh done");
      complete_run();
   end
endmodule
